// File: verilog/pro_pkg.sv
/*
  pro_pkg: operation codes, pixel size codes and reset values for the raster-op unit.
  assumes one 16-bit memory word per transfer, pixels packed from bit 0 upward.
*/
`default_nettype none
package pro_pkg;
  // ----------------------------------------
  // word layout
  // ----------------------------------------
  localparam int              WORD_W   = 16;
  localparam logic [15:0]     RST_WORD = 16'h0000;

  // ----------------------------------------
  // pixel_op_select codes
  // ----------------------------------------
  localparam logic [4:0] OP_REPLACE      = 5'h00;
  localparam logic [4:0] OP_AND          = 5'h01;
  localparam logic [4:0] OP_AND_NDST     = 5'h02;
  localparam logic [4:0] OP_ZEROS        = 5'h03;
  localparam logic [4:0] OP_OR_NDST      = 5'h04;
  localparam logic [4:0] OP_XNOR         = 5'h05;
  localparam logic [4:0] OP_NDST         = 5'h06;
  localparam logic [4:0] OP_NOR          = 5'h07;
  localparam logic [4:0] OP_OR           = 5'h08;
  localparam logic [4:0] OP_KEEP         = 5'h09;
  localparam logic [4:0] OP_XOR          = 5'h0a;
  localparam logic [4:0] OP_NSRC_AND     = 5'h0b;
  localparam logic [4:0] OP_ONES         = 5'h0c;
  localparam logic [4:0] OP_NSRC_OR      = 5'h0d;
  localparam logic [4:0] OP_NAND         = 5'h0e;
  localparam logic [4:0] OP_NSRC         = 5'h0f;
  localparam logic [4:0] OP_ADD          = 5'h10;
  localparam logic [4:0] OP_ADD_SATURATE = 5'h11;
  localparam logic [4:0] OP_SUB          = 5'h12;
  localparam logic [4:0] OP_SUB_SATURATE = 5'h13;
  localparam logic [4:0] OP_MAX          = 5'h14;
  localparam logic [4:0] OP_MIN          = 5'h15;
  localparam logic [4:0] OP_FIRST_RSVD   = 5'h16;

  // ----------------------------------------
  // pixel size codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PSZ_1  = 3'h0,
    PSZ_2  = 3'h1,
    PSZ_4  = 3'h2,
    PSZ_8  = 3'h3,
    PSZ_16 = 3'h4
  } pro_psize_t;
endpackage : pro_pkg
`default_nettype wire

// File: verilog/pro_mask_if.sv
/*
  pro_mask_if: carries the processed word to the result-mask and transparency stage.
  assumes the producer drives every field combinationally in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
interface pro_mask_if;
  logic [15:0]        raw;
  logic [15:0]        mask;
  pro_pkg::pro_psize_t psize;
  logic               xp_en;
  logic               suppress;
  logic [15:0]        masked;
  logic [15:0]        wr_en;

  modport prod (output raw, mask, psize, xp_en, suppress, input masked, wr_en);
  modport msk  (input raw, mask, psize, xp_en, suppress, output masked, wr_en);
endinterface : pro_mask_if
`default_nettype wire

// File: verilog/pro_arith_lane.sv
/*
  pro_arith_lane: unsigned arithmetic on one pixel of width W.
  assumes op is one of the arithmetic codes; anything else returns the destination.
*/
`timescale 1ns/1ns
`default_nettype none
module pro_arith_lane #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] src,
  input  wire logic [W-1:0] dst,
  input  wire logic [4:0]   op,
  output logic      [W-1:0] res
);
  import pro_pkg::*;

  logic [W:0] sum;
  logic [W:0] diff;

  // lane is W+1 wide so carry and borrow stay inside this pixel
  assign sum  = {1'b0, src} + {1'b0, dst};
  assign diff = {1'b0, dst} - {1'b0, src};

  always_comb begin
    case (op)
      OP_ADD:          res = sum[W-1:0];
      OP_ADD_SATURATE: res = sum[W] ? {W{1'b1}} : sum[W-1:0];
      OP_SUB:          res = diff[W-1:0];
      OP_SUB_SATURATE: res = diff[W] ? {W{1'b0}} : diff[W-1:0];
      OP_MAX:          res = (src > dst) ? src : dst;
      OP_MIN:          res = (src < dst) ? src : dst;
      default:         res = dst;
    endcase
  end
endmodule : pro_arith_lane
`default_nettype wire

// File: verilog/pro_mask_xparent.sv
/*
  pro_mask_xparent: masks the processed word and builds the per-bit write enable.
  assumes mask bit 1 protects a bit; the whole word is suppressed on request.
*/
`timescale 1ns/1ns
`default_nettype none
module pro_mask_xparent (
  pro_mask_if.msk mi
);
  import pro_pkg::*;

  logic [15:0] zf;

  // ----------------------------------------
  // result masking
  // ----------------------------------------
  assign mi.masked = mi.raw & ~mi.mask;

  // ----------------------------------------
  // per-pixel zero detect on the masked word
  // ----------------------------------------
  always_comb begin
    for (int b = 0; b < 16; b++) begin
      case (mi.psize)
        PSZ_1:   zf[b] = ~mi.masked[b];
        PSZ_2:   zf[b] = ~|mi.masked[(b / 2) * 2 +: 2];
        PSZ_4:   zf[b] = ~|mi.masked[(b / 4) * 4 +: 4];
        PSZ_8:   zf[b] = ~|mi.masked[(b / 8) * 8 +: 8];
        default: zf[b] = ~|mi.masked;
      endcase
    end
  end

  // protected bits and transparent pixels are never written
  assign mi.wr_en = ~mi.mask & ~(mi.xp_en ? zf : 16'h0000) & {16{~mi.suppress}};
endmodule : pro_mask_xparent
`default_nettype wire

// File: verilog/pixel_raster_op_unit.sv
/*
  pixel_raster_op_unit: combines a source word with a destination word per pixel and
  hands back the result word, its bit write enables and read-modify-write hints.
  assumes the sequencer presents both words with START and that the plane mask is
  already replicated across the word; one request per cycle, answer one cycle later.

  // Operation
  // - boolean ops act bit by bit for 1, 2, 4, 8 or 16 bit pixels
  // - arithmetic treats pixels as unsigned, only for 4, 8 or 16 bits
  // - a five-bit select picks one of twenty-two operations
  // - 00000 source, 00001 and, 00010 source and not dest, 00011 zeros
  // - 00100 source or not dest, 00101 xnor, 00110 not dest, 00111 nor
  // - 01000 or, 01001 keep dest, 01010 xor, 01011 not source and dest
  // - 01100 ones, 01101 not source or dest, 01110 nand, 01111 not source
  // - 10000 writes source plus dest, 10010 writes dest minus source
  // - plain add and subtract wrap within the pixel width
  // - carries and borrows never cross into a neighbouring pixel
  // - 10001 add_saturate but clamps to all ones on overflow
  // - 10011 subtracts but clamps to zero on underflow
  // - 10100 writes the larger, 10101 the smaller, unsigned
  // - each source pixel combines with its own destination pixel, written back there
  // - memory operands get the plane mask before the operation
  // - the plane mask zeroes protected result bits after the operation
  // - transparency is judged on the masked result, the write comes last
  // - replace needs no destination read and no combining
  // - read-modify-write only when masking or transparency below 16 bits, or unaligned
  // - mask one reads as zero and is never written; zero leaves bit free
  // - sources from registers skip operand masking
  // - with transparency on, an all-zero pixel is not written
*/
`timescale 1ns/1ns
`default_nettype none
module pixel_raster_op_unit (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire logic                START,
  input  wire logic [15:0]         SRC_WORD,
  input  wire logic [15:0]         DST_WORD,
  input  wire logic                SRC_FROM_REG,
  input  wire logic [4:0]          PIXEL_OP_SELECT,
  input  wire pro_pkg::pro_psize_t PIXEL_SIZE,
  input  wire logic [15:0]         PLANE_PROTECT_MASK,
  input  wire logic                TRANSP_EN,
  input  wire logic                WORD_ALIGNED,
  output logic                     RESULT_VALID,
  output logic [15:0]              RESULT_WORD,
  output logic [15:0]              WRITE_EN_MASK,
  output logic                     NEED_DST_READ,
  output logic                     NEED_RMW,
  output logic                     ARITH_UNDEFINED
);
  import pro_pkg::*;

  logic [15:0] src_m;
  logic [15:0] dst_m;
  logic [15:0] bool_res;
  logic [15:0] arith4;
  logic [15:0] arith8;
  logic [15:0] arith16;
  logic [15:0] arith_res;
  logic [15:0] op_res;
  logic        is_arith;
  logic        is_rsvd;
  logic        arith_ok;
  logic        rmw_need;
  logic        valid_ff;
  logic [15:0] result_ff;
  logic [15:0] wr_en_ff;
  logic        dst_rd_ff;
  logic        rmw_ff;
  logic        undef_ff;

  pro_mask_if mif ();

  // ----------------------------------------
  // operand masking
  // ----------------------------------------
  assign src_m = SRC_FROM_REG ? SRC_WORD : (SRC_WORD & ~PLANE_PROTECT_MASK);
  assign dst_m = DST_WORD & ~PLANE_PROTECT_MASK;

  assign is_rsvd  = PIXEL_OP_SELECT >= OP_FIRST_RSVD;
  assign is_arith = PIXEL_OP_SELECT[4] && !is_rsvd;
  // 1 and 2 bit pixels have no arithmetic; such a request keeps the destination
  assign arith_ok = (PIXEL_SIZE == PSZ_4) || (PIXEL_SIZE == PSZ_8) || (PIXEL_SIZE == PSZ_16);

  // ----------------------------------------
  // boolean operations over the whole word
  // ----------------------------------------
  always_comb begin
    case (PIXEL_OP_SELECT[3:0])
      4'h0:    bool_res = src_m;
      4'h1:    bool_res = src_m & dst_m;
      4'h2:    bool_res = src_m & ~dst_m;
      4'h3:    bool_res = 16'h0000;
      4'h4:    bool_res = src_m | ~dst_m;
      4'h5:    bool_res = ~(src_m ^ dst_m);
      4'h6:    bool_res = ~dst_m;
      4'h7:    bool_res = ~(src_m | dst_m);
      4'h8:    bool_res = src_m | dst_m;
      4'h9:    bool_res = dst_m;
      4'ha:    bool_res = src_m ^ dst_m;
      4'hb:    bool_res = ~src_m & dst_m;
      4'hc:    bool_res = 16'hffff;
      4'hd:    bool_res = ~src_m | dst_m;
      4'he:    bool_res = ~(src_m & dst_m);
      4'hf:    bool_res = ~src_m;
      default: bool_res = dst_m;
    endcase
  end

  // ----------------------------------------
  // arithmetic lanes, one set per 4, 8 and 16 bit pixel size
  // ----------------------------------------
  // all three lane sets run at once; cheaper than carry-kill muxes in one adder
  for (genvar g = 0; g < 4; g++) begin : g_lane4
    pro_arith_lane #(.W(4)) u_lane (
      .src (src_m[g*4 +: 4]),
      .dst (dst_m[g*4 +: 4]),
      .op  (PIXEL_OP_SELECT),
      .res (arith4[g*4 +: 4])
    );
  end
  for (genvar g = 0; g < 2; g++) begin : g_lane8
    pro_arith_lane #(.W(8)) u_lane (
      .src (src_m[g*8 +: 8]),
      .dst (dst_m[g*8 +: 8]),
      .op  (PIXEL_OP_SELECT),
      .res (arith8[g*8 +: 8])
    );
  end
  pro_arith_lane #(.W(16)) u_lane16 (
    .src (src_m),
    .dst (dst_m),
    .op  (PIXEL_OP_SELECT),
    .res (arith16)
  );

  always_comb begin
    case (PIXEL_SIZE)
      PSZ_4:   arith_res = arith4;
      PSZ_8:   arith_res = arith8;
      PSZ_16:  arith_res = arith16;
      default: arith_res = dst_m;
    endcase
  end

  // reserved codes pass the masked destination through, like arithmetic at 1 or 2 bits
  assign op_res = is_rsvd ? dst_m : (is_arith ? arith_res : bool_res);

  // ----------------------------------------
  // result mask and transparency
  // ----------------------------------------
  assign mif.raw      = op_res;
  assign mif.mask     = PLANE_PROTECT_MASK;
  assign mif.psize    = PIXEL_SIZE;
  assign mif.xp_en    = TRANSP_EN;
  assign mif.suppress = is_rsvd || (is_arith && !arith_ok);

  pro_mask_xparent u_mask (
    .mi (mif)
  );

  assign rmw_need = ((PLANE_PROTECT_MASK != 16'h0000 || TRANSP_EN) && PIXEL_SIZE != PSZ_16) || !WORD_ALIGNED;

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= START;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      result_ff <= RST_WORD;
      wr_en_ff  <= RST_WORD;
    end else if (START) begin
      result_ff <= mif.masked;
      wr_en_ff  <= mif.wr_en;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dst_rd_ff <= 1'b0;
      rmw_ff    <= 1'b0;
      undef_ff  <= 1'b0;
    end else if (START) begin
      dst_rd_ff <= (PIXEL_OP_SELECT != OP_REPLACE) || rmw_need;
      rmw_ff    <= rmw_need;
      undef_ff  <= is_arith && !arith_ok;
    end
  end

  assign RESULT_VALID    = valid_ff;
  assign RESULT_WORD     = result_ff;
  assign WRITE_EN_MASK   = wr_en_ff;
  assign NEED_DST_READ   = dst_rd_ff;
  assign NEED_RMW        = rmw_ff;
  assign ARITH_UNDEFINED = undef_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_valid_after_start: assert property (START |=> RESULT_VALID ##0 $past(START))
    else $error("valid does not follow start");
  a_protect_not_written: assert property (START |=> (WRITE_EN_MASK & $past(PLANE_PROTECT_MASK)) == 16'h0000)
    else $error("protected bit enabled for write");
  a_protect_reads_zero: assert property (START |=> (RESULT_WORD & $past(PLANE_PROTECT_MASK)) == 16'h0000)
    else $error("protected result bit not zero");
  a_reserved_no_write: assert property (START && PIXEL_OP_SELECT >= OP_FIRST_RSVD |=> WRITE_EN_MASK == 16'h0000)
    else $error("reserved op writes");
  a_zero_fill: assert property (START && PIXEL_OP_SELECT == OP_ZEROS |=> RESULT_WORD == 16'h0000)
    else $error("zeros op wrong");
  a_xor_word: assert property (START && PIXEL_OP_SELECT == OP_XOR && PLANE_PROTECT_MASK == 16'h0000
                               |=> RESULT_WORD == ($past(SRC_WORD) ^ $past(DST_WORD)))
    else $error("xor result wrong");
  a_add_wrap16: assert property (START && PIXEL_OP_SELECT == OP_ADD && PIXEL_SIZE == PSZ_16
                                 && PLANE_PROTECT_MASK == 16'h0000
                                 |=> RESULT_WORD == 16'($past(SRC_WORD) + $past(DST_WORD)))
    else $error("16-bit add wrong");
  a_add_sat_clamp: assert property (START && PIXEL_OP_SELECT == OP_ADD_SATURATE && PIXEL_SIZE == PSZ_8
                                    && PLANE_PROTECT_MASK == 16'h0000 && SRC_WORD[7] && DST_WORD[7]
                                    |=> RESULT_WORD[7:0] == 8'hff)
    else $error("saturating add not clamped");
  a_sub_sat_floor: assert property (START && PIXEL_OP_SELECT == OP_SUB_SATURATE && PIXEL_SIZE == PSZ_4
                                    && PLANE_PROTECT_MASK == 16'h0000 && SRC_WORD[3:0] > DST_WORD[3:0]
                                    |=> RESULT_WORD[3:0] == 4'h0)
    else $error("saturating subtract not floored");
  a_transp_skip: assert property (START && TRANSP_EN && PIXEL_OP_SELECT == OP_ZEROS |=> WRITE_EN_MASK == 16'h0000)
    else $error("transparent pixel written");
  a_replace_no_read: assert property (START && PIXEL_OP_SELECT == OP_REPLACE && WORD_ALIGNED
                                      && !TRANSP_EN && PLANE_PROTECT_MASK == 16'h0000 |=> !NEED_DST_READ)
    else $error("replace reads destination");
  a_rmw_unaligned: assert property (START && !WORD_ALIGNED |=> NEED_RMW)
    else $error("unaligned write without rmw");

  // ----------------------------------------
  // checks on lane arithmetic and write control
  // ----------------------------------------
  // word-wide references only hold with a clear mask, so most of these gate on it
  a_undef_no_write: assert property (START && PIXEL_OP_SELECT >= OP_ADD && PIXEL_OP_SELECT < OP_FIRST_RSVD
      && (PIXEL_SIZE == PSZ_1 || PIXEL_SIZE == PSZ_2)
      |=> WRITE_EN_MASK == 16'h0000 && ARITH_UNDEFINED)
    else $error("undefined arithmetic writes");
  a_undef_flag_clear: assert property (START && PIXEL_SIZE == PSZ_16 |=> !ARITH_UNDEFINED)
    else $error("16-bit pixels flagged undefined");
  a_ones_fill: assert property (START && PIXEL_OP_SELECT == OP_ONES && PLANE_PROTECT_MASK == 16'h0000
      |=> RESULT_WORD == 16'hffff)
    else $error("ones op wrong");
  a_nand_word: assert property (START && PIXEL_OP_SELECT == OP_NAND && PLANE_PROTECT_MASK == 16'h0000
      |=> RESULT_WORD == ~($past(SRC_WORD) & $past(DST_WORD)))
    else $error("nand result wrong");
  a_keep_dest: assert property (START && PIXEL_OP_SELECT == OP_KEEP
      |=> RESULT_WORD == ($past(DST_WORD) & ~$past(PLANE_PROTECT_MASK)))
    else $error("keep op changed destination");
  a_rsvd_keeps_dst: assert property (START && PIXEL_OP_SELECT >= OP_FIRST_RSVD
      |=> RESULT_WORD == ($past(DST_WORD) & ~$past(PLANE_PROTECT_MASK)))
    else $error("reserved op altered result");
  a_sub_wrap16: assert property (START && PIXEL_OP_SELECT == OP_SUB && PIXEL_SIZE == PSZ_16
      && PLANE_PROTECT_MASK == 16'h0000
      |=> RESULT_WORD == 16'($past(DST_WORD) - $past(SRC_WORD)))
    else $error("16-bit subtract wrong");
  a_sat_add16: assert property (START && PIXEL_OP_SELECT == OP_ADD_SATURATE && PIXEL_SIZE == PSZ_16
      && PLANE_PROTECT_MASK == 16'h0000
      |=> RESULT_WORD == (({1'b0, $past(SRC_WORD)} + {1'b0, $past(DST_WORD)}) > 17'h0ffff
                          ? 16'hffff : 16'($past(SRC_WORD) + $past(DST_WORD))))
    else $error("16-bit saturating add wrong");
  a_sat_sub16: assert property (START && PIXEL_OP_SELECT == OP_SUB_SATURATE && PIXEL_SIZE == PSZ_16
      && PLANE_PROTECT_MASK == 16'h0000
      |=> RESULT_WORD == (($past(SRC_WORD) > $past(DST_WORD)) ? 16'h0000 : 16'($past(DST_WORD) - $past(SRC_WORD))))
    else $error("16-bit saturating subtract wrong");
  a_max16: assert property (START && PIXEL_OP_SELECT == OP_MAX && PIXEL_SIZE == PSZ_16
      && PLANE_PROTECT_MASK == 16'h0000
      |=> RESULT_WORD == (($past(SRC_WORD) > $past(DST_WORD)) ? $past(SRC_WORD) : $past(DST_WORD)))
    else $error("max result wrong");
  a_min16: assert property (START && PIXEL_OP_SELECT == OP_MIN && PIXEL_SIZE == PSZ_16
      && PLANE_PROTECT_MASK == 16'h0000
      |=> RESULT_WORD == (($past(SRC_WORD) < $past(DST_WORD)) ? $past(SRC_WORD) : $past(DST_WORD)))
    else $error("min result wrong");
  a_lane4_carry: assert property (START && PIXEL_OP_SELECT == OP_ADD && PIXEL_SIZE == PSZ_4
      && PLANE_PROTECT_MASK == 16'h0000
      |=> RESULT_WORD[7:4] == 4'($past(SRC_WORD[7:4]) + $past(DST_WORD[7:4])))
    else $error("carry crossed into next pixel");
  a_rmw_full16: assert property (START && WORD_ALIGNED && PIXEL_SIZE == PSZ_16 |=> !NEED_RMW)
    else $error("aligned 16-bit write asks for rmw");
  a_full_write: assert property (START && PLANE_PROTECT_MASK == 16'h0000 && !TRANSP_EN
      && PIXEL_OP_SELECT < OP_ADD |=> WRITE_EN_MASK == 16'hffff)
    else $error("free bits not written");
  a_need_read: assert property (START && PIXEL_OP_SELECT != OP_REPLACE |=> NEED_DST_READ)
    else $error("combining op skips destination read");
  a_valid_needs_start: assert property (RESULT_VALID |-> $past(START))
    else $error("valid without start");

  c_replace: cover property (START && PIXEL_OP_SELECT == OP_REPLACE ##1 RESULT_VALID);
  c_add_sat8: cover property (START && PIXEL_OP_SELECT == OP_ADD_SATURATE && PIXEL_SIZE == PSZ_8);
  c_transp:  cover property (START && TRANSP_EN ##1 WRITE_EN_MASK != 16'hffff);
  c_back2:   cover property (START [*3]);
  c_rsvd:    cover property (START && PIXEL_OP_SELECT >= OP_FIRST_RSVD ##1 WRITE_EN_MASK == 16'h0000);
endmodule : pixel_raster_op_unit
`default_nettype wire

// File: verif/pro_mem_model.sv
/*
  pro_mem_model: behavioural local memory that feeds destination words and takes back results.
  assumes one request per start and the answer exactly one cycle later.
*/
`timescale 1ns/1ns
`default_nettype none
module pro_mem_model (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [1:0]  addr,
  input  wire logic        result_valid,
  input  wire logic [15:0] result_word,
  input  wire logic [15:0] write_en_mask,
  output logic      [15:0] dst_word
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] mem [4];
  logic [1:0]  wr_addr_ff;

  // unqualified read shows the inverse so a late sample cannot match by luck
  assign dst_word = start ? mem[addr] : ~mem[addr];

  always @(posedge clk) begin
    if (start) wr_addr_ff <= addr;
  end

  // only enabled bits change; protected bits keep their old value
  always @(posedge clk) begin
    if (result_valid) mem[wr_addr_ff] <= (mem[wr_addr_ff] & ~write_en_mask) | (result_word & write_en_mask);
  end
endmodule : pro_mem_model
`default_nettype wire

// File: verif/pixel_raster_op_unit_tb_top.sv
/*
  pixel_raster_op_unit_tb_top: self-checking bench for the raster-op unit.
  assumes the memory model supplies destination words; inputs change at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module pixel_raster_op_unit_tb_top;
  import pro_pkg::*;
  logic        clk, rst_n, start, from_reg, xp, aligned;
  logic        rv, ndr, rmw, und;
  logic [4:0]  op;
  logic [1:0]  addr;
  logic [15:0] src, mask, dst, rw, wen;
  pro_psize_t  psize;
  int          error_cnt, num_checks;

  pixel_raster_op_unit dut (.CLK(clk), .RST_N(rst_n), .START(start), .SRC_WORD(src), .DST_WORD(dst),
    .SRC_FROM_REG(from_reg), .PIXEL_OP_SELECT(op), .PIXEL_SIZE(psize), .PLANE_PROTECT_MASK(mask),
    .TRANSP_EN(xp), .WORD_ALIGNED(aligned), .RESULT_VALID(rv), .RESULT_WORD(rw), .WRITE_EN_MASK(wen),
    .NEED_DST_READ(ndr), .NEED_RMW(rmw), .ARITH_UNDEFINED(und));
  pro_mem_model u_mem (.clk(clk), .start(start), .addr(addr), .result_valid(rv), .result_word(rw),
    .write_en_mask(wen), .dst_word(dst));

  // ----------------------------------------
  // reference and checking
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // lane-by-lane model; int lanes keep carries out of the neighbours
  function automatic void ref_calc(input logic [4:0] o, input pro_psize_t sz, input logic [15:0] s, d, m,
                                   input logic x, fr, output logic [15:0] res, we, output logic un);
    int w, lm, a, b, sp, dp, r;
    w = 1 << int'(sz);
    lm = (1 << w) - 1;
    a = fr ? s : (s & ~m);
    b = d & ~m;
    un = o[4] && o < OP_FIRST_RSVD && w < 4;
    res = 16'h0000;
    we = ~m;
    for (int p = 0; p < 16; p += w) begin
      sp = (a >> p) & lm;
      dp = (b >> p) & lm;
      case (o)
        5'h00: r = sp;
        5'h01: r = sp & dp;
        5'h02: r = sp & ~dp;
        5'h03: r = 0;
        5'h04: r = sp | ~dp;
        5'h05: r = ~(sp ^ dp);
        5'h06: r = ~dp;
        5'h07: r = ~(sp | dp);
        5'h08: r = sp | dp;
        5'h0a: r = sp ^ dp;
        5'h0b: r = ~sp & dp;
        5'h0c: r = -1;
        5'h0d: r = ~sp | dp;
        5'h0e: r = ~(sp & dp);
        5'h0f: r = ~sp;
        5'h10: r = sp + dp;
        5'h11: r = (sp + dp > lm) ? lm : sp + dp;
        5'h12: r = dp - sp;
        5'h13: r = (dp < sp) ? 0 : dp - sp;
        5'h14: r = (sp > dp) ? sp : dp;
        5'h15: r = (sp < dp) ? sp : dp;
        default: r = dp;
      endcase
      // arithmetic on 1 or 2 bit pixels keeps the destination
      if (un) r = dp;
      if (un || o >= OP_FIRST_RSVD) we = we & ~16'(lm << p);
      res = res | 16'((r & lm) << p);
    end
    res = res & ~m;
    for (int p = 0; p < 16; p += w) begin
      if (x && ((res >> p) & lm) == 0) we = we & ~16'(lm << p);
    end
  endfunction : ref_calc

  task automatic do_op(input logic [4:0] o, input pro_psize_t sz, input logic [15:0] s, d, m,
                       input logic x, fr, al);
    logic [15:0] er, ew;
    logic        eu, erm;
    int          n;
    ref_calc(o, sz, s, d, m, x, fr, er, ew, eu);
    erm = ((m != 16'h0000 || x) && sz != PSZ_16) || !al;
    @(negedge clk);
    u_mem.mem[0] = d;
    {addr, op, psize, src, mask, xp, from_reg, aligned, start} = {2'h0, o, sz, s, m, x, fr, al, 1'b1};
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (rv !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk(rv, 1'b1);
    chk(rw, er);
    chk(rw, er);
    chk(wen, ew);
    chk(rmw, erm);
    chk(ndr, o != OP_REPLACE || erm);
    chk(und, eu);
    @(negedge clk);
    chk(rv, 1'b0);
    chk(rw, er);
    chk(u_mem.mem[0], (d & ~ew) | (er & ew));
  endtask : do_op

  // three requests on consecutive edges, same words, different ops and pixel sizes
  task automatic back_to_back;
    logic [15:0] er [3];
    logic [15:0] ew [3];
    logic        eu;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      if (k > 0) begin
        chk(rv, 1'b1);
        chk(rw, er[k-1]);
        chk(wen, ew[k-1]);
      end
      if (k < 3) begin
        ref_calc(5'h10 + 5'(2 * k), pro_psize_t'(k + 2), 16'hb7e1, 16'h48d2, 16'h0000, 1'b0, 1'b0,
                 er[k], ew[k], eu);
        u_mem.mem[k] = 16'h48d2;
        {addr, op, psize, src, mask, xp, start} = {2'(k), 5'h10 + 5'(2 * k), pro_psize_t'(k + 2),
                                                  16'hb7e1, 16'h0000, 1'b0, 1'b1};
      end else begin
        start = 1'b0;
      end
    end
  endtask : back_to_back

  task automatic test_done;
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // about 1200 cycles expected; ten thousand is ample
  initial begin
    #1000000;
    error_cnt++;
    test_done();
  end

  initial begin
    {rst_n, start, from_reg, xp, aligned, op, addr, src, mask} = '0;
    psize = PSZ_1;
    error_cnt = 0;
    num_checks = 0;
    repeat (20) @(negedge clk);
    chk(rw, 16'h0000);
    chk(wen, 16'h0000);
    chk({rv, ndr, rmw, und}, 16'h0000);
    rst_n = 1'b1;
    for (int z = 0; z < 5; z++) begin
      for (int o = 0; o < 32; o++) begin
        do_op(5'(o), pro_psize_t'(z), 16'h9c6f, 16'h7ab5, 16'h0000, 1'b0, 1'b0, 1'b1);
        do_op(5'(o), pro_psize_t'(z), 16'h1234, 16'h4321, 16'h0000, 1'b0, 1'b0, 1'b1);
      end
    end
    for (int i = 0; i < 64; i++) begin
      do_op(i[5] ? OP_REPLACE : OP_SUB_SATURATE, i[4] ? PSZ_16 : PSZ_4, 16'h0f30, 16'h0a55,
            i[3] ? 16'h2222 : 16'h0000, i[0], i[1], i[2]);
    end
    back_to_back();
    // reset in mid-run clears every output, then the unit takes work again
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk(rw, 16'h0000);
    chk(wen, 16'h0000);
    chk({rv, ndr, rmw, und}, 16'h0000);
    rst_n = 1'b1;
    do_op(OP_ADD, PSZ_8, 16'h80f1, 16'h8022, 16'h0000, 1'b0, 1'b0, 1'b1);
    test_done();
  end
endmodule : pixel_raster_op_unit_tb_top
`default_nettype wire
